//--- hdl/rns_sleep_ctrl.sv
/*
  Sleep-state controller of a radio node, with a Wishbone classic slave.
  Assumes host pins and node events are synchronous to clk_i; data_rx_i,
  sync_rx_i and sync_req_rx_i are one-cycle event pulses.
*/
// Implementation choices: the Wishbone slave port and the address map.
// What this block does
// - Mode 0, the reset default, never sleeps and stays awake.
// - Mode 0 relays sync messages once synchronized but never originates one.
// - Mode 0 routes traffic at any time, ignoring network wake phase.
// - Mode 1 with request high finishes activity, then sleeps.
// - Mode 1 wakes when the host lowers the sleep request.
// - Asynchronous modes send one poll per wake when polling enabled.
// - Mode 4 sleeps a period, wakes briefly, sleeps again without data.
// - Timed cyclic sleep drives awake indicator high awake, low asleep.
// - With flow control on, CTS low when awake, high asleep.
// - Mode 5 cycles while request high, wakes and stays awake while low.
// - Mode 7 synchronizes, never sleeps, answers sync requests anytime once synchronized.
// - Mode 7 holds ordinary data until the network is awake.
// - Mode 8 follows network phases, accepts nothing while asleep.
// - Mode 8 uses own durations until synchronized, then network ones.
// - Mode 8 drives awake indicator only when its pin config is 1.
// - Mode 8 with handshake config 1 holds CTS deasserted asleep.
// - Unsynchronized mode 8 listens, sleeps own period, repeats until sync.
// - Modes 4 and 5 start time-until-sleep timer on data arrival.
// - Each further data arrival restarts the timer at full length.
// - Timer loads from wake time; expiry sends the node to sleep.
// - Coordinator sends one sync per wake start; receivers relay it.
// - A non-coordinator never acts as coordinator; it originates sync only to answer sync requests in mode 7.
module rns_sleep_ctrl #(
  parameter int unsigned TICK_CYCLES = rns_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // Wishbone classic slave
  input  wire logic [7:0]               wb_adr_i,
  input  wire logic [31:0]              wb_dat_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic                     wb_we_i,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  output logic [31:0]                   wb_dat_o,
  output logic                          wb_ack_o,
  // Host pins
  input  wire logic                     sleep_request_in_i,
  output logic                          awake_indicator_o,
  output logic                          cts_n_o,
  // Node events
  input  wire logic                     busy_i,
  input  wire logic                     data_rx_i,
  input  wire logic                     sync_rx_i,
  input  wire logic [rns_pkg::DUR_W-1:0] sync_sleep_i,
  input  wire logic [rns_pkg::DUR_W-1:0] sync_wake_i,
  input  wire logic                     sync_req_rx_i,
  // Node actions
  output logic                          poll_o,
  output logic                          sync_tx_o,
  output logic                          sync_relay_o,
  output logic                          route_en_o,
  output logic                          data_tx_en_o,
  output logic                          rx_accept_o
);
  localparam int unsigned DW = rns_pkg::DUR_W;

  // Configuration
  logic [3:0]    mode_q, mode_d;
  logic          hs_cfg_q, hs_cfg_d;
  logic          awk_cfg_q, awk_cfg_d;
  logic          poll_en_q, poll_en_d;
  logic          non_coord_q, non_coord_d;
  logic          pref_coord_q, pref_coord_d;
  logic [DW-1:0] sleep_period_q, sleep_period_d;
  logic [DW-1:0] wake_time_q, wake_time_d;
  logic [31:0]   rdat_d;
  logic          ack_d;

  // Sleep state
  rns_pkg::rns_state_t state_q, state_d;
  logic          synced_q, synced_d;
  logic          net_awake_q, net_awake_d;
  logic          relayed_q, relayed_d;
  logic [DW-1:0] net_sleep_q, net_sleep_d;
  logic [DW-1:0] net_wake_q, net_wake_d;
  logic          ind_d, cts_n_d, poll_d, sync_tx_d, relay_d;
  logic          route_d, txen_d, rxacc_d, awake_d;

  // Helpers
  logic [31:0]   wmask, ctrl_word, ctrl_new, stat_word;
  logic          wr;
  logic          tick;
  logic          until_load, until_run, until_exp;
  logic          phase_load, phase_run, phase_exp;
  logic [DW-1:0] until_val, phase_val;
  logic          coord, pin_hold, sync_ok, wake_start;
  logic [DW-1:0] own_sleep, own_wake;

  rns_tick #(.DIV(TICK_CYCLES)) u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (tick)
  );

  // Time until sleep
  rns_timer #(.W(DW)) u_until (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .tick_i     (tick),
    .load_i     (until_load),
    .load_val_i (until_val),
    .run_o      (until_run),
    .expire_o   (until_exp)
  );

  // Sleep period or network phase
  rns_timer #(.W(DW)) u_phase (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .tick_i     (tick),
    .load_i     (phase_load),
    .load_val_i (phase_val),
    .run_o      (phase_run),
    .expire_o   (phase_exp)
  );

  for (genvar b = 0; b < 4; b++) begin : g_mask
    assign wmask[8*b +: 8] = {8{wb_sel_i[b]}};
  end

  // Register bus
  always_comb begin
    ctrl_word = '0;
    ctrl_word[rns_pkg::CTRL_MODE_LSB +: 4] = mode_q;
    ctrl_word[rns_pkg::CTRL_HS_BIT]   = hs_cfg_q;
    ctrl_word[rns_pkg::CTRL_AWK_BIT]  = awk_cfg_q;
    ctrl_word[rns_pkg::CTRL_POLL_BIT] = poll_en_q;
    ctrl_word[rns_pkg::CTRL_NONC_BIT] = non_coord_q;
    ctrl_word[rns_pkg::CTRL_PREF_BIT] = pref_coord_q;
    stat_word = '0;
    stat_word[rns_pkg::STAT_AWAKE_BIT]  = (state_q != rns_pkg::RNS_SLEEP);
    stat_word[rns_pkg::STAT_SYNC_BIT]   = synced_q;
    stat_word[rns_pkg::STAT_COORD_BIT]  = coord;
    stat_word[rns_pkg::STAT_NETAWK_BIT] = net_awake_q;
    stat_word[rns_pkg::STAT_STATE_LSB +: 2] = state_q;
    ctrl_new = (ctrl_word & ~wmask) | (wb_dat_i & wmask);
    // Write lands on the edge where the master sees ack
    wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    ack_d = wb_cyc_i && wb_stb_i && !wb_ack_o;
    mode_d = mode_q;
    hs_cfg_d = hs_cfg_q;
    awk_cfg_d = awk_cfg_q;
    poll_en_d = poll_en_q;
    non_coord_d = non_coord_q;
    pref_coord_d = pref_coord_q;
    sleep_period_d = sleep_period_q;
    wake_time_d = wake_time_q;
    rdat_d = wb_dat_o;
    if (wr) begin
      unique case (wb_adr_i)
        rns_pkg::REG_CTRL: begin
          mode_d = ctrl_new[rns_pkg::CTRL_MODE_LSB +: 4];
          hs_cfg_d = ctrl_new[rns_pkg::CTRL_HS_BIT];
          awk_cfg_d = ctrl_new[rns_pkg::CTRL_AWK_BIT];
          poll_en_d = ctrl_new[rns_pkg::CTRL_POLL_BIT];
          non_coord_d = ctrl_new[rns_pkg::CTRL_NONC_BIT];
          pref_coord_d = ctrl_new[rns_pkg::CTRL_PREF_BIT];
        end
        rns_pkg::REG_SP: sleep_period_d = DW'(({16'h0, sleep_period_q} & ~wmask)
                                               | (wb_dat_i & wmask));
        rns_pkg::REG_ST: wake_time_d = DW'(({16'h0, wake_time_q} & ~wmask)
                                            | (wb_dat_i & wmask));
        default: ;
      endcase
    end
    if (ack_d) begin
      unique case (wb_adr_i)
        rns_pkg::REG_CTRL:   rdat_d = ctrl_word;
        rns_pkg::REG_SP:     rdat_d = {16'h0, sleep_period_q};
        rns_pkg::REG_ST:     rdat_d = {16'h0, wake_time_q};
        rns_pkg::REG_STATUS: rdat_d = stat_word;
        rns_pkg::REG_NETDUR: rdat_d = {net_wake_q, net_sleep_q};
        default:             rdat_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q         <= rns_pkg::MODE_RST;
      hs_cfg_q       <= 1'b0;
      awk_cfg_q      <= 1'b0;
      poll_en_q      <= 1'b0;
      non_coord_q    <= 1'b0;
      pref_coord_q   <= 1'b0;
      sleep_period_q <= rns_pkg::SP_RST;
      wake_time_q    <= rns_pkg::ST_RST;
      wb_dat_o       <= 32'h0000_0000;
      wb_ack_o       <= 1'b0;
    end else begin
      mode_q         <= mode_d;
      hs_cfg_q       <= hs_cfg_d;
      awk_cfg_q      <= awk_cfg_d;
      poll_en_q      <= poll_en_d;
      non_coord_q    <= non_coord_d;
      pref_coord_q   <= pref_coord_d;
      sleep_period_q <= sleep_period_d;
      wake_time_q    <= wake_time_d;
      wb_dat_o       <= rdat_d;
      wb_ack_o       <= ack_d;
    end
  end

  // Sleep control
  always_comb begin
    coord = pref_coord_q && !non_coord_q
            && (mode_q == rns_pkg::MODE_SUPPORT || mode_q == rns_pkg::MODE_SYNC);
    pin_hold = (mode_q == rns_pkg::MODE_CYC_PIN) && !sleep_request_in_i;
    // Asleep radio hears nothing, so a sync then is dropped
    sync_ok = sync_rx_i && !coord
              && !(mode_q == rns_pkg::MODE_SYNC && state_q == rns_pkg::RNS_SLEEP);
    own_sleep = synced_q ? net_sleep_q : sleep_period_q;
    own_wake = synced_q ? net_wake_q : wake_time_q;
    state_d = state_q;
    synced_d = synced_q;
    net_awake_d = net_awake_q;
    relayed_d = relayed_q;
    net_sleep_d = net_sleep_q;
    net_wake_d = net_wake_q;
    poll_d = 1'b0;
    sync_tx_d = 1'b0;
    relay_d = 1'b0;
    until_load = 1'b0;
    until_val = wake_time_q;
    phase_load = 1'b0;
    phase_val = own_wake;
    wake_start = 1'b0;
    unique case (mode_q)
      rns_pkg::MODE_PIN: begin
        unique case (state_q)
          rns_pkg::RNS_AWAKE: if (sleep_request_in_i) state_d = rns_pkg::RNS_DRAIN;
          rns_pkg::RNS_DRAIN: begin
            if (!sleep_request_in_i) state_d = rns_pkg::RNS_AWAKE;
            else if (!busy_i) state_d = rns_pkg::RNS_SLEEP;
          end
          rns_pkg::RNS_SLEEP: if (!sleep_request_in_i) begin
            state_d = rns_pkg::RNS_AWAKE;
            poll_d = poll_en_q;
          end
          default: state_d = rns_pkg::RNS_AWAKE;
        endcase
      end
      rns_pkg::MODE_CYC, rns_pkg::MODE_CYC_PIN: begin
        unique case (state_q)
          rns_pkg::RNS_AWAKE: begin
            if (pin_hold) state_d = rns_pkg::RNS_AWAKE;
            else if (data_rx_i) until_load = 1'b1;
            else if (until_exp || !until_run) state_d = rns_pkg::RNS_DRAIN;
          end
          rns_pkg::RNS_DRAIN: begin
            if (pin_hold) state_d = rns_pkg::RNS_AWAKE;
            else if (!busy_i) begin
              state_d = rns_pkg::RNS_SLEEP;
              phase_load = 1'b1;
              phase_val = sleep_period_q;
            end
          end
          rns_pkg::RNS_SLEEP: if (pin_hold || phase_exp) begin
            state_d = rns_pkg::RNS_AWAKE;
            poll_d = poll_en_q;
            // Brief listen of one tick before sleeping again
            until_load = !pin_hold;
            until_val = DW'(1);
          end
          default: state_d = rns_pkg::RNS_AWAKE;
        endcase
      end
      rns_pkg::MODE_AWAKE, rns_pkg::MODE_SUPPORT, rns_pkg::MODE_SYNC: begin
        if (sync_ok) begin
          synced_d = 1'b1;
          net_sleep_d = sync_sleep_i;
          net_wake_d = sync_wake_i;
          net_awake_d = 1'b1;
          phase_load = 1'b1;
          phase_val = sync_wake_i;
          relay_d = !relayed_q;
          relayed_d = 1'b1;
        end else if (phase_exp || !phase_run) begin
          net_awake_d = phase_exp ? !net_awake_q : 1'b1;
          phase_load = 1'b1;
          phase_val = net_awake_d ? own_wake : own_sleep;
          wake_start = net_awake_d;
        end
        if (wake_start) relayed_d = 1'b0;
        if (wake_start && coord) begin
          sync_tx_d = 1'b1;
          synced_d = 1'b1;
          net_sleep_d = own_sleep;
          net_wake_d = own_wake;
        end
        if (mode_q == rns_pkg::MODE_SUPPORT && sync_req_rx_i && synced_q)
          sync_tx_d = 1'b1;
        state_d = (mode_q == rns_pkg::MODE_SYNC && !net_awake_d)
                  ? rns_pkg::RNS_SLEEP : rns_pkg::RNS_AWAKE;
      end
      default: state_d = rns_pkg::RNS_AWAKE;
    endcase
    awake_d = (state_d != rns_pkg::RNS_SLEEP);
    ind_d = awake_d && (mode_q != rns_pkg::MODE_SYNC || awk_cfg_q);
    cts_n_d = hs_cfg_q && !awake_d;
    route_d = (mode_q == rns_pkg::MODE_AWAKE)
              || (awake_d && (mode_q == rns_pkg::MODE_SUPPORT
                              || mode_q == rns_pkg::MODE_SYNC));
    txen_d = awake_d && (mode_q != rns_pkg::MODE_SUPPORT
                         || (synced_d && net_awake_d));
    rxacc_d = awake_d;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q           <= rns_pkg::RNS_AWAKE;
      synced_q          <= 1'b0;
      net_awake_q       <= 1'b0;
      relayed_q         <= 1'b0;
      net_sleep_q       <= rns_pkg::SP_RST;
      net_wake_q        <= rns_pkg::ST_RST;
      awake_indicator_o <= 1'b1;
      cts_n_o           <= 1'b0;
      poll_o            <= 1'b0;
      sync_tx_o         <= 1'b0;
      sync_relay_o      <= 1'b0;
      route_en_o        <= 1'b1;
      data_tx_en_o      <= 1'b1;
      rx_accept_o       <= 1'b1;
    end else begin
      state_q           <= state_d;
      synced_q          <= synced_d;
      net_awake_q       <= net_awake_d;
      relayed_q         <= relayed_d;
      net_sleep_q       <= net_sleep_d;
      net_wake_q        <= net_wake_d;
      awake_indicator_o <= ind_d;
      cts_n_o           <= cts_n_d;
      poll_o            <= poll_d;
      sync_tx_o         <= sync_tx_d;
      sync_relay_o      <= relay_d;
      route_en_o        <= route_d;
      data_tx_en_o      <= txen_d;
      rx_accept_o       <= rxacc_d;
    end
  end

  property p_mode0_awake;
    @(posedge clk_i) disable iff (rst_i)
      mode_q == rns_pkg::MODE_AWAKE |=> state_q == rns_pkg::RNS_AWAKE && route_en_o;
  endproperty
  a_mode0_awake: assert property (p_mode0_awake) else $error("mode 0 left awake");

  property p_mode0_no_sync;
    @(posedge clk_i) disable iff (rst_i) mode_q == rns_pkg::MODE_AWAKE |=> !sync_tx_o;
  endproperty
  a_mode0_no_sync: assert property (p_mode0_no_sync) else $error("mode 0 sent sync");

  property p_pin_drain;
    @(posedge clk_i) disable iff (rst_i)
      (mode_q == rns_pkg::MODE_PIN && state_q == rns_pkg::RNS_DRAIN && busy_i)
      |=> state_q != rns_pkg::RNS_SLEEP;
  endproperty
  a_pin_drain: assert property (p_pin_drain) else $error("slept during activity");

  property p_pin_wake;
    @(posedge clk_i) disable iff (rst_i)
      (mode_q == rns_pkg::MODE_PIN && state_q == rns_pkg::RNS_SLEEP && !sleep_request_in_i)
      |=> state_q == rns_pkg::RNS_AWAKE && poll_o == $past(poll_en_q);
  endproperty
  a_pin_wake: assert property (p_pin_wake) else $error("pin wake or poll missing");

  property p_cyc_ind;
    @(posedge clk_i) disable iff (rst_i)
      (mode_q == rns_pkg::MODE_CYC && $stable(mode_q))
      |-> awake_indicator_o == (state_q != rns_pkg::RNS_SLEEP);
  endproperty
  a_cyc_ind: assert property (p_cyc_ind) else $error("awake indicator wrong");

  property p_cts;
    @(posedge clk_i) disable iff (rst_i)
      (hs_cfg_q && $stable(hs_cfg_q)) |-> cts_n_o == (state_q == rns_pkg::RNS_SLEEP);
  endproperty
  a_cts: assert property (p_cts) else $error("CTS does not follow sleep");

  property p_pin_hold;
    @(posedge clk_i) disable iff (rst_i)
      (mode_q == rns_pkg::MODE_CYC_PIN && !sleep_request_in_i)
      |=> state_q == rns_pkg::RNS_AWAKE;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("mode 5 slept with pin low");

  property p_sync_deaf;
    @(posedge clk_i) disable iff (rst_i)
      (mode_q == rns_pkg::MODE_SYNC && $stable(mode_q) && state_q == rns_pkg::RNS_SLEEP)
      |-> !rx_accept_o;
  endproperty
  a_sync_deaf: assert property (p_sync_deaf) else $error("accepting data asleep");

  property p_until_data;
    @(posedge clk_i) disable iff (rst_i)
      (mode_q == rns_pkg::MODE_CYC && state_q == rns_pkg::RNS_AWAKE && data_rx_i)
      |=> until_run ##1 state_q == rns_pkg::RNS_AWAKE;
  endproperty
  a_until_data: assert property (p_until_data) else $error("data did not hold wake");

  c_cyc_wake: cover property (@(posedge clk_i) disable iff (rst_i)
    mode_q == rns_pkg::MODE_CYC && state_q == rns_pkg::RNS_SLEEP ##1
    state_q == rns_pkg::RNS_AWAKE);
  c_sync_lock: cover property (@(posedge clk_i) disable iff (rst_i)
    mode_q == rns_pkg::MODE_SYNC && !synced_q ##1 synced_q);
  c_poll: cover property (@(posedge clk_i) disable iff (rst_i) poll_o);
endmodule // rns_sleep_ctrl

//--- hdl/rns_pkg.sv
/*
  Shared constants and types of the radio node sleep controller.
  Assumes a 250 MHz system clock and a 1 ms timebase for all durations.
*/
package rns_pkg;
  // Clock and timebase
  localparam int unsigned CLK_PERIOD_NS  = 4;
  localparam int unsigned TICK_PERIOD_NS = 1000000;
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned DUR_W          = 16;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_SP     = 8'h04;
  localparam logic [7:0] REG_ST     = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_NETDUR = 8'h10;

  // Control field positions
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_HS_BIT   = 4;
  localparam int unsigned CTRL_AWK_BIT  = 5;
  localparam int unsigned CTRL_POLL_BIT = 6;
  localparam int unsigned CTRL_NONC_BIT = 7;
  localparam int unsigned CTRL_PREF_BIT = 8;

  // Status field positions
  localparam int unsigned STAT_AWAKE_BIT  = 0;
  localparam int unsigned STAT_SYNC_BIT   = 1;
  localparam int unsigned STAT_COORD_BIT  = 2;
  localparam int unsigned STAT_NETAWK_BIT = 3;
  localparam int unsigned STAT_STATE_LSB  = 4;
  localparam int unsigned NETDUR_WAKE_LSB = 16;

  // Sleep mode codes
  localparam logic [3:0] MODE_AWAKE   = 4'h0;
  localparam logic [3:0] MODE_PIN     = 4'h1;
  localparam logic [3:0] MODE_CYC     = 4'h4;
  localparam logic [3:0] MODE_CYC_PIN = 4'h5;
  localparam logic [3:0] MODE_SUPPORT = 4'h7;
  localparam logic [3:0] MODE_SYNC    = 4'h8;

  // Reset values
  localparam logic [3:0]       MODE_RST = MODE_AWAKE;
  localparam logic [DUR_W-1:0] SP_RST   = 16'h00C8;
  localparam logic [DUR_W-1:0] ST_RST   = 16'h07D0;

  typedef enum logic [1:0] {
    RNS_AWAKE = 2'h0,
    RNS_DRAIN = 2'h1,
    RNS_SLEEP = 2'h2
  } rns_state_t;
endpackage

//--- hdl/rns_tick.sv
/*
  Timebase divider: one-cycle enable every DIV clocks.
  Assumes a single free running clock with synchronous reset.
*/
module rns_tick #(
  parameter int unsigned DIV = rns_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Timebase
  output logic      tick_o
);
  localparam int unsigned CW = $clog2(DIV + 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          tick_d;

  always_comb begin
    tick_d = (cnt_q == CW'(DIV - 1));
    cnt_d  = tick_d ? '0 : cnt_q + CW'(1);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_o <= tick_d;
    end
  end
endmodule // rns_tick

//--- hdl/rns_timer.sv
/*
  Reloadable down-counter stepped by a timebase tick.
  Assumes tick_i is a one-cycle enable in the same clock domain.
*/
module rns_timer #(
  parameter int unsigned W = rns_pkg::DUR_W
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Control
  input  wire logic         tick_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  // Status
  output logic              run_o,
  output logic              expire_o
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         run_d;
  logic         exp_d;

  always_comb begin
    cnt_d = cnt_q;
    run_d = run_o;
    exp_d = 1'b0;
    if (load_i) begin
      // Zero would wrap to a full count before expiring, so it counts as one tick
      cnt_d = (load_val_i == '0) ? W'(1) : load_val_i;
      run_d = 1'b1;
    end else if (run_o && tick_i) begin
      if (cnt_q == W'(1)) begin
        cnt_d = '0;
        run_d = 1'b0;
        exp_d = 1'b1;
      end else begin
        cnt_d = cnt_q - W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q    <= '0;
      run_o    <= 1'b0;
      expire_o <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      run_o    <= run_d;
      expire_o <= exp_d;
    end
  end

  property p_expire_pulse;
    @(posedge clk_i) disable iff (rst_i) expire_o |=> !expire_o;
  endproperty
  a_expire_pulse: assert property (p_expire_pulse) else $error("expiry longer than a cycle");

  property p_reload;
    @(posedge clk_i) disable iff (rst_i)
      (load_i && load_val_i > W'(1)) |=> (run_o && !expire_o && cnt_q == $past(load_val_i));
  endproperty
  a_reload: assert property (p_reload) else $error("reload did not restart timer");
endmodule // rns_timer

//--- sim/rns_host_model.sv
/*
  Host model: drives the sleep request and the activity pin.
  Assumes the bench commands it on clk_i rising edges.
*/
module rns_host_model (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Bench commands
  input  wire logic req_cmd_i,
  input  wire logic busy_cmd_i,
  // Pins to the controller
  output logic      sleep_request_o,
  output logic      busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Request held as a level; lowering it is the only way to wake in mode 1
  always_ff @(posedge clk_i) begin
    sleep_request_o <= rst_i ? 1'b0 : req_cmd_i;
    busy_o          <= rst_i ? 1'b0 : busy_cmd_i;
  end
endmodule // rns_host_model

//--- sim/tb_rns_sleep_ctrl.sv
/*
  Self-checking bench of the sleep controller.
  Assumes a short timebase; the sync request input stays idle.
*/
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb_rns_sleep_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0, req = 0, busy = 0, rq, bz;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, rd, wb_dat_o;
  logic wb_ack_o, awk, cts_n, poll, route, relay, txen, rxa;
  logic drx = 0, srx = 0;
  logic [15:0] ssl = 16'h0000, swk = 16'h0000;
  int n_tests = 0, n_mismatch = 0, cyc_cnt = 0, k;
  logic [3:0] mode_r [6] = '{4'h0, 4'h1, 4'h1, 4'h5, 4'h7, 4'h2};
  logic       req_r  [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
  logic       awk_r  [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  rns_host_model rns_host_model_inst (.clk_i(clk_i), .rst_i(rst_i), .req_cmd_i(req),
    .busy_cmd_i(busy), .sleep_request_o(rq), .busy_o(bz));
  rns_sleep_ctrl #(.TICK_CYCLES(4)) rns_sleep_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_request_in_i(rq),
    .awake_indicator_o(awk), .cts_n_o(cts_n), .busy_i(bz), .data_rx_i(drx),
    .sync_rx_i(srx), .sync_sleep_i(ssl), .sync_wake_i(swk),
    .sync_req_rx_i(1'b0), .poll_o(poll), .sync_tx_o(), .sync_relay_o(relay),
    .route_en_o(route), .data_tx_en_o(txen), .rx_accept_o(rxa));
  initial forever #2 clk_i = ~clk_i;
  task automatic conclude();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    adr <= a; dat <= d; we <= w; cyc <= 1'b1; stb <= 1'b1;
    n = 0;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 50);
    if (n >= 50) begin
      n_mismatch++;
      conclude();
    end
    rd = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  always @(posedge clk_i) if (++cyc_cnt == 20000) begin n_mismatch++; conclude(); end
  initial begin
    hold(12);
    rst_i <= 1'b0;
    wb(0, 8'h00, 0); `CHK("ctrl", 32'h0, rd)
    wb(0, 8'h04, 0); `CHK("sp", 32'h000000C8, rd)
    wb(0, 8'h08, 0); `CHK("st", 32'h000007D0, rd)
    wb(0, 8'h3C, 0); `CHK("unmapped", 32'h0, rd)
    `CHK("route", 1'b1, route)
    $display("test reset done");
    // Mode table: each row sets mode and request, then looks at the pin
    for (int i = 0; i < 6; i++) begin
      req <= req_r[i];
      wb(1, 8'h00, {28'h0, mode_r[i]});
      hold(6);
      `CHK("awake", awk_r[i], awk)
    end
    $display("test modes done");
    // Drain waits for activity, then sleeps with CTS high; wake polls once
    busy <= 1'b1;
    wb(1, 8'h00, 32'h00000051);
    req <= 1'b1;
    hold(6);
    wb(0, 8'h0C, 0); `CHK("drain", 2'h1, rd[5:4])
    busy <= 1'b0;
    hold(4);
    wb(0, 8'h0C, 0); `CHK("asleep", 2'h2, rd[5:4])
    `CHK("cts", 1'b1, cts_n)
    req <= 1'b0;
    k = 0;
    repeat (8) begin @(posedge clk_i); k += (poll === 1'b1); end
    `CHK("polls", 1, k)
    `CHK("cts", 1'b0, cts_n)
    $display("test drain done");
    // Mode 8: one sync locks the node, is relayed once, then it sleeps deaf
    wb(1, 8'h00, 32'h00000028);
    srx <= 1'b1;
    ssl <= 16'h0002;
    swk <= 16'h0003;
    @(posedge clk_i);
    srx <= 1'b0;
    k = 0;
    repeat (4) begin @(posedge clk_i); k += (relay === 1'b1); end
    `CHK("relays", 1, k)
    wb(0, 8'h0C, 0); `CHK("synced", 1'b1, rd[1])
    wb(0, 8'h10, 0); `CHK("net dur", 32'h00030002, rd)
    k = 0;
    while (rxa !== 1'b0 && k < 40) begin @(posedge clk_i); k++; end
    `CHK("deaf", 1'b0, rxa)
    `CHK("tx off", 1'b0, txen)
    `CHK("ind off", 1'b0, awk)
    $display("test sync done");
    // Mode 5 with request high: data holds wake, a second arrival reloads
    wb(1, 8'h08, 32'h00000003);
    wb(1, 8'h00, 32'h00000005);
    req <= 1'b1;
    @(posedge clk_i);
    drx <= 1'b1;
    @(posedge clk_i);
    drx <= 1'b0;
    hold(5);
    `CHK("held", 1'b1, awk)
    drx <= 1'b1;
    @(posedge clk_i);
    drx <= 1'b0;
    hold(10);
    `CHK("reload", 1'b1, awk)
    k = 0;
    while (awk !== 1'b0 && k < 20) begin @(posedge clk_i); k++; end
    `CHK("expired", 1'b0, awk)
    $display("test timer done");
    // Reset in mid-run from sleep restores awake defaults
    rst_i <= 1'b1;
    hold(2);
    `CHK("rst awake", 1'b1, awk)
    `CHK("rst cts", 1'b0, cts_n)
    rst_i <= 1'b0;
    wb(0, 8'h08, 0); `CHK("rst st", 32'h000007D0, rd)
    wb(0, 8'h00, 0); `CHK("rst ctrl", 32'h0, rd)
    $display("test rerun reset done");
    conclude();
  end
endmodule // tb_rns_sleep_ctrl
